// File: elog_pkg.sv
// Purpose: Shared constants and types for the event logger with overload guard
// Assumes: One 100 MHz clock, 1 ms stamp tick derived from it
// Notes: Recorder event codes follow bit order of the change detector
package elog_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TS_RES_MS = 1;
    localparam int TS_RES_NS = TS_RES_MS * 1000000;
    // Least time, rounded up to whole cycles
    localparam int TICK_CYCLES = (TS_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIST_DEPTH = 15000;
    localparam int RATE_LIMIT = 200;
    localparam int RATE_WINDOW_S = 1;
    localparam int RATE_WINDOW_MS = RATE_WINDOW_S * 1000 / TS_RES_MS;
    localparam int HOLD_S = 5;
    localparam int HOLD_MS = HOLD_S * 1000 / TS_RES_MS;
    localparam int SRC_W = 4;
    localparam int CODE_W = 8;
    localparam int TS_W = 32;
    localparam int REC_EVENTS = 11;
    localparam logic [SRC_W-1:0] REC_SRC = 4'hf;

    typedef enum logic [CODE_W-1:0] {
        ELOG_TRIG_ON, ELOG_TRIG_OFF, ELOG_MEM_CLEARED, ELOG_OLDEST_CLEARED,
        ELOG_FULL_ON, ELOG_FULL_OFF, ELOG_RECORDING_ON, ELOG_RECORDING_OFF,
        ELOG_STORING_ON, ELOG_STORING_OFF, ELOG_NEWEST_CLEARED
    } elog_rec_code_type;

    typedef struct packed {
        logic [SRC_W-1:0] src;
        logic [CODE_W-1:0] code;
    } elog_evt_type;

    typedef struct packed {
        logic [TS_W-1:0] stamp;
        elog_evt_type evt;
    } elog_rec_type;
endpackage

// File: elog_rate_guard.sv
// Purpose: Event rate window counter, overload blocking and fault report
// Assumes: tick_in is a one-cycle pulse every millisecond
// Notes: Fixed (not sliding) window; hits are counted even while blocked
`timescale 1ns/100ps
module elog_rate_guard #(
    parameter int LIMIT = elog_pkg::RATE_LIMIT,
    parameter int WINDOW_MS = elog_pkg::RATE_WINDOW_MS,
    parameter int HOLD_MS = elog_pkg::HOLD_MS
) (
    input wire logic core_clk_in, // System clock
    input wire logic nrst_in, // Async reset, active low
    input wire logic tick_in, // Millisecond pulse
    input wire logic hit_in, // One event generated this cycle
    input wire logic fault_clr_in, // Request to clear the fault report
    output logic block_out, // Logging blocked
    output logic fault_out // Internal fault report
);
    localparam int CW = $clog2(LIMIT + 2);
    localparam int WW = $clog2(WINDOW_MS + 1);
    localparam int HW = $clog2(HOLD_MS + 1);

    if (LIMIT < 1 || WINDOW_MS < 1 || HOLD_MS < 1) begin : bad_cfg
        $error("elog_rate_guard: limit, window and hold must be positive");
    end

    typedef enum logic {ELOG_RUN, ELOG_HOLD} elog_guard_type;

    elog_guard_type state, next_state;
    logic [CW-1:0] ev_cnt, next_ev_cnt;
    logic [WW-1:0] win_cnt, next_win_cnt;
    logic [HW-1:0] hold_cnt, next_hold_cnt;
    logic last_over, next_last_over;
    logic next_block, next_fault;
    logic win_end, over_now;

    always_comb begin
        win_end = tick_in && (win_cnt == WW'(WINDOW_MS - 1));
        over_now = ev_cnt > CW'(LIMIT);
        next_win_cnt = tick_in ? (win_end ? '0 : win_cnt + 1'b1) : win_cnt;
        // Count keeps running while blocked so recovery can be seen
        if (win_end) begin
            next_ev_cnt = hit_in ? CW'(1) : '0;
        end else if (hit_in && !over_now) begin
            next_ev_cnt = ev_cnt + 1'b1;
        end else begin
            next_ev_cnt = ev_cnt;
        end
        next_last_over = win_end ? over_now : last_over;
        next_state = state;
        next_hold_cnt = hold_cnt;
        next_block = block_out;
        unique case (state)
            ELOG_RUN: begin
                if (over_now) begin
                    next_state = ELOG_HOLD;
                    next_block = 1'b1;
                    next_hold_cnt = '0;
                end
            end
            ELOG_HOLD: begin
                if (tick_in) begin
                    if (hold_cnt == HW'(HOLD_MS - 1)) begin
                        next_hold_cnt = '0;
                        // Release only if the rate is back within the limit
                        if (!last_over && !over_now) begin
                            next_state = ELOG_RUN;
                            next_block = 1'b0;
                        end
                    end else begin
                        next_hold_cnt = hold_cnt + 1'b1;
                    end
                end
            end
        endcase
        // Set wins over clear; clear only once released
        if (state == ELOG_RUN && over_now) begin
            next_fault = 1'b1;
        end else if (fault_clr_in && !block_out) begin
            next_fault = 1'b0;
        end else begin
            next_fault = fault_out;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= ELOG_RUN;
            ev_cnt <= '0;
            win_cnt <= '0;
            hold_cnt <= '0;
            last_over <= 1'b0;
            block_out <= 1'b0;
            fault_out <= 1'b0;
        end else begin
            state <= next_state;
            ev_cnt <= next_ev_cnt;
            win_cnt <= next_win_cnt;
            hold_cnt <= next_hold_cnt;
            last_over <= next_last_over;
            block_out <= next_block;
            fault_out <= next_fault;
        end
    end

    over_block_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (state == ELOG_RUN && ev_cnt == CW'(LIMIT) && hit_in && !win_end) ##1 1'b1 |=> block_out)
        else $error("overload not blocked after limit exceeded");
    fault_with_block_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        block_out |-> fault_out)
        else $error("blocked without fault report");
    release_hold_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        $fell(block_out) |-> $past(hold_cnt) == HW'(HOLD_MS - 1) && !$past(last_over))
        else $error("block released before hold end or while over limit");
    count_runs_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (block_out && hit_in && !win_end && !over_now) |=> ev_cnt == $past(ev_cnt) + 1'b1)
        else $error("rate count stopped while blocked");
    enter_c: cover property (@(posedge core_clk_in) disable iff (!nrst_in) $rose(block_out));
    release_c: cover property (@(posedge core_clk_in) disable iff (!nrst_in) $fell(block_out));
endmodule

// File: elog_logger.sv
// Purpose: Time-stamped circular event history with masking and overload guard
// Assumes: Event sources and reader run on core_clk_in
// Notes: Function events are never stalled; recorder events wait in a pending set
`timescale 1ns/100ps
module elog_logger #(
    parameter int TICK_CYCLES = elog_pkg::TICK_CYCLES,
    parameter int DEPTH = elog_pkg::HIST_DEPTH,
    parameter int LIMIT = elog_pkg::RATE_LIMIT,
    parameter int WINDOW_MS = elog_pkg::RATE_WINDOW_MS,
    parameter int HOLD_MS = elog_pkg::HOLD_MS
) (
    input wire logic core_clk_in, // System clock
    input wire logic nrst_in, // Async reset, active low
    input wire logic fn_evt_valid_in, // Function status change, one cycle
    input elog_pkg::elog_evt_type fn_evt_in, // Source and code of that change
    input wire logic [(1<<elog_pkg::SRC_W)-1:0] fn_mask_in, // Per-source log enable; source REC_SRC is logged whatever its bit
    input wire logic rec_trig_in, // Recorder triggered level
    input wire logic rec_full_in, // Recorder memory full level
    input wire logic rec_recording_in, // Recording level
    input wire logic rec_storing_in, // Storing recording level
    input wire logic rec_mem_clr_in, // Memory cleared pulse
    input wire logic rec_old_clr_in, // Oldest record cleared pulse
    input wire logic rec_new_clr_in, // Newest record cleared pulse
    input wire logic fault_clr_in, // Clear fault report
    input wire logic rd_req_in, // Read request, one cycle
    input wire logic [$clog2(DEPTH)-1:0] rd_idx_in, // Index, 0 is oldest
    output logic rd_valid_out, // Read answer pulse
    output logic rd_ok_out, // Index was inside the history
    output elog_pkg::elog_rec_type rd_rec_out, // Record read
    output logic [$clog2(DEPTH+1)-1:0] fill_out, // Records held
    output logic [elog_pkg::TS_W-1:0] stamp_out, // Millisecond time
    output logic blocked_out, // Logging blocked by overload
    output logic internal_fault_report_out // Overload fault report
);
    localparam int PW = $clog2(DEPTH);
    localparam int FW = $clog2(DEPTH + 1);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int NR = elog_pkg::REC_EVENTS;
    localparam int RW = $bits(elog_pkg::elog_rec_type);

    if (DEPTH < 2 || TICK_CYCLES < 1) begin : bad_cfg
        $error("elog_logger: depth below 2 or tick below 1 cycle");
    end

    function automatic logic [PW-1:0] wrap_add(input logic [PW-1:0] a, input logic [PW-1:0] b);
        logic [PW:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= (PW+1)'(DEPTH)) begin
            s = s - (PW+1)'(DEPTH);
        end
        return s[PW-1:0];
    endfunction

    // Large array kept here; one write and one read port per cycle
    logic [RW-1:0] hist_mem [DEPTH];

    logic [TW-1:0] pre_cnt, next_pre_cnt;
    logic tick, next_tick;
    logic [elog_pkg::TS_W-1:0] next_stamp;
    logic [PW-1:0] head, next_head, wr_ptr, next_wr_ptr;
    logic [FW-1:0] next_fill;
    logic [NR-1:0] pend, next_pend, new_bits, take_bit;
    logic [3:0] lvl_q, next_lvl_q;
    logic fn_hit, rec_take, hit, wr_en;
    logic [elog_pkg::CODE_W-1:0] rec_code;
    elog_pkg::elog_rec_type wr_rec;
    logic next_rd_valid, next_rd_ok;
    logic [PW-1:0] rd_addr;

    // Millisecond time base
    always_comb begin
        next_tick = pre_cnt == TW'(TICK_CYCLES - 1);
        next_pre_cnt = next_tick ? '0 : pre_cnt + 1'b1;
        next_stamp = tick ? stamp_out + 1'b1 : stamp_out;
    end

    // Recorder change detector and pending set
    always_comb begin
        next_lvl_q = {rec_storing_in, rec_recording_in, rec_full_in, rec_trig_in};
        new_bits = {rec_new_clr_in,
                    ~rec_storing_in & lvl_q[3], rec_storing_in & ~lvl_q[3],
                    ~rec_recording_in & lvl_q[2], rec_recording_in & ~lvl_q[2],
                    ~rec_full_in & lvl_q[1], rec_full_in & ~lvl_q[1],
                    rec_old_clr_in, rec_mem_clr_in,
                    ~rec_trig_in & lvl_q[0], rec_trig_in & ~lvl_q[0]};
        rec_code = '0;
        take_bit = '0;
        for (int i = NR - 1; i >= 0; i--) begin
            if (pend[i]) begin
                rec_code = elog_pkg::CODE_W'(i);
                take_bit = NR'(1) << i;
            end
        end
        // Function events are never held off; recorder drains in gaps
        fn_hit = fn_evt_valid_in &&
                 (fn_mask_in[fn_evt_in.src] || fn_evt_in.src == elog_pkg::REC_SRC);
        rec_take = (pend != '0) && !fn_hit;
        // New change wins over the drain of the same bit
        next_pend = (pend & ~(rec_take ? take_bit : '0)) | new_bits;
        hit = fn_hit || rec_take;
        wr_en = hit && !blocked_out;
        wr_rec.stamp = stamp_out;
        wr_rec.evt.src = fn_hit ? fn_evt_in.src : elog_pkg::REC_SRC;
        wr_rec.evt.code = fn_hit ? fn_evt_in.code : rec_code;
    end

    // Circular history pointers
    always_comb begin
        next_wr_ptr = wr_en ? wrap_add(wr_ptr, PW'(1)) : wr_ptr;
        next_head = head;
        next_fill = fill_out;
        if (wr_en) begin
            if (fill_out == FW'(DEPTH)) begin
                next_head = wrap_add(head, PW'(1));
            end else begin
                next_fill = fill_out + 1'b1;
            end
        end
        rd_addr = wrap_add(head, rd_idx_in);
        next_rd_valid = rd_req_in;
        next_rd_ok = rd_req_in && (FW'(rd_idx_in) < fill_out);
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pre_cnt <= '0;
            tick <= 1'b0;
            stamp_out <= '0;
            lvl_q <= '0;
            pend <= '0;
            head <= '0;
            wr_ptr <= '0;
            fill_out <= '0;
            rd_valid_out <= 1'b0;
            rd_ok_out <= 1'b0;
        end else begin
            pre_cnt <= next_pre_cnt;
            tick <= next_tick;
            stamp_out <= next_stamp;
            lvl_q <= next_lvl_q;
            pend <= next_pend;
            head <= next_head;
            wr_ptr <= next_wr_ptr;
            fill_out <= next_fill;
            rd_valid_out <= next_rd_valid;
            rd_ok_out <= next_rd_ok;
        end
    end

    // Memory ports carry no reset; the data path is qualified by fill
    always_ff @(posedge core_clk_in) begin
        if (wr_en) begin
            hist_mem[wr_ptr] <= wr_rec;
        end
        if (rd_req_in) begin
            rd_rec_out <= hist_mem[rd_addr];
        end
    end

    // Guard sees only the hit; its stall never reaches the sources
    elog_rate_guard #(
        .LIMIT(LIMIT),
        .WINDOW_MS(WINDOW_MS),
        .HOLD_MS(HOLD_MS)
    ) u_guard (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .tick_in(tick),
        .hit_in(hit),
        .fault_clr_in(fault_clr_in),
        .block_out(blocked_out),
        .fault_out(internal_fault_report_out)
    );

    // Cycles since the last tick; the stamp period check uses this instead of a long delay
    logic [TW-1:0] tick_gap, next_tick_gap;
    logic tick_seen, next_tick_seen;

    always_comb begin
        next_tick_gap = tick ? '0 : tick_gap + 1'b1;
        next_tick_seen = tick_seen || tick;
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tick_gap <= '0;
            tick_seen <= 1'b0;
        end else begin
            tick_gap <= next_tick_gap;
            tick_seen <= next_tick_seen;
        end
    end

    fill_cap_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        fill_out <= FW'(DEPTH))
        else $error("history fill above depth");
    drop_oldest_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (wr_en && fill_out == FW'(DEPTH)) |=> fill_out == FW'(DEPTH) &&
        head == wrap_add($past(head), PW'(1)))
        else $error("oldest record not dropped on full write");
    fill_grow_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (wr_en && fill_out < FW'(DEPTH)) |=> fill_out == $past(fill_out) + 1'b1)
        else $error("history did not grow on write");
    mask_drop_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (fn_evt_valid_in && !fn_mask_in[fn_evt_in.src] && fn_evt_in.src != elog_pkg::REC_SRC
        && pend == '0) |=> fill_out == $past(fill_out) && head == $past(head))
        else $error("masked event written");
    block_nowrite_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        blocked_out |=> fill_out == $past(fill_out) && head == $past(head))
        else $error("history changed while blocked");
    rec_catch_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        $rose(rec_trig_in) |=> pend[0])
        else $error("recorder trigger change not caught");
    rec_logged_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (pend != '0 && !fn_evt_valid_in && !blocked_out) |-> wr_en && wr_rec.evt.src ==
        elog_pkg::REC_SRC)
        else $error("recorder event not logged in idle cycle");
    stamp_step_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        1'b1 |=> stamp_out == $past(stamp_out) + $past(tick))
        else $error("stamp not advancing once per tick");
    tick_period_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        (tick && tick_seen) |-> tick_gap == TW'(TICK_CYCLES - 1))
        else $error("millisecond tick period wrong");
    read_lat_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        rd_req_in |=> rd_valid_out ##1 !rd_valid_out || $past(rd_req_in))
        else $error("read answer not one cycle after request");
    wrap_c: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
        wr_en && fill_out == FW'(DEPTH));
    rec_write_c: cover property (@(posedge core_clk_in) disable iff (!nrst_in) rec_take && wr_en);
    blocked_drop_c: cover property (@(posedge core_clk_in) disable iff (!nrst_in)
        hit && blocked_out);
endmodule

// File: elog_src_model.sv
// Purpose: Event sources facing the logger: function events and recorder status
// Assumes: Tasks are entered at a falling edge of core_clk_in
// Notes: Never waits on the logger, as a real source cannot be stalled
`timescale 1ns/100ps
module elog_src_model (
    input wire logic core_clk_in, // System clock
    output logic fn_evt_valid_out, // Function event strobe
    output elog_pkg::elog_evt_type fn_evt_out, // Function event source and code
    output logic [3:0] rec_lvl_out, // Store, recording, full, trigger levels
    output logic [2:0] rec_pls_out // Newest, oldest, memory cleared pulses
);
    initial begin
        fn_evt_valid_out = 1'b0;
        fn_evt_out = '0;
        rec_lvl_out = 4'h0;
        rec_pls_out = 3'h0;
    end

    // Trailing edge wait keeps back to back calls from reassigning one step
    task automatic fn_send(input logic [3:0] src, input logic [7:0] code, input int n);
        fn_evt_valid_out = 1'b1;
        fn_evt_out = {src, code};
        repeat (n) @(negedge core_clk_in);
        fn_evt_valid_out = 1'b0;
        @(negedge core_clk_in);
    endtask

    // Action k produces the recorder status change whose event code is k
    task automatic rec_act(input int k);
        case (k)
            0: rec_lvl_out[0] = 1'b1;
            1: rec_lvl_out[0] = 1'b0;
            2: rec_pls_out[0] = 1'b1;
            3: rec_pls_out[1] = 1'b1;
            4: rec_lvl_out[1] = 1'b1;
            5: rec_lvl_out[1] = 1'b0;
            6: rec_lvl_out[2] = 1'b1;
            7: rec_lvl_out[2] = 1'b0;
            8: rec_lvl_out[3] = 1'b1;
            9: rec_lvl_out[3] = 1'b0;
            default: rec_pls_out[2] = 1'b1;
        endcase
        @(negedge core_clk_in);
        rec_pls_out = 3'h0;
        @(negedge core_clk_in);
    endtask
endmodule

// File: tb.sv
// Purpose: Self-checking bench for the time-stamped event logger
// Assumes: Tick, window, hold and depth shortened by parameters
// Notes: Inputs change at the falling edge only
`timescale 1ns/100ps
module tb;
    localparam int TICK = 10;
    localparam int HOLD = 50;
    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [15:0] fn_mask_in = 16'h0000;
    logic fault_clr_in = 1'b0;
    logic rd_req_in = 1'b0;
    logic [2:0] rd_idx_in = 3'h0;
    logic fn_evt_valid;
    elog_pkg::elog_evt_type fn_evt;
    logic [3:0] rec_lvl;
    logic [2:0] rec_pls;
    logic rd_valid_out;
    logic rd_ok_out;
    logic ok_q;
    elog_pkg::elog_rec_type rd_rec_out;
    elog_pkg::elog_rec_type rec_q;
    logic [3:0] fill_out;
    logic [31:0] stamp_out;
    logic blocked_out;
    logic internal_fault_report_out;
    int err_total = 0;
    int samples_checked = 0;

    initial begin
        forever #5 core_clk_in = ~core_clk_in;
    end

    elog_src_model src_u (.core_clk_in(core_clk_in), .fn_evt_valid_out(fn_evt_valid),
        .fn_evt_out(fn_evt), .rec_lvl_out(rec_lvl), .rec_pls_out(rec_pls));

    elog_logger #(.TICK_CYCLES(TICK), .DEPTH(8), .LIMIT(4), .WINDOW_MS(20),
        .HOLD_MS(HOLD)) dut_u (
        .core_clk_in(core_clk_in), .nrst_in(nrst_in), .fn_evt_valid_in(fn_evt_valid),
        .fn_evt_in(fn_evt), .fn_mask_in(fn_mask_in), .rec_trig_in(rec_lvl[0]),
        .rec_full_in(rec_lvl[1]), .rec_recording_in(rec_lvl[2]),
        .rec_storing_in(rec_lvl[3]), .rec_mem_clr_in(rec_pls[0]),
        .rec_old_clr_in(rec_pls[1]), .rec_new_clr_in(rec_pls[2]),
        .fault_clr_in(fault_clr_in), .rd_req_in(rd_req_in), .rd_idx_in(rd_idx_in),
        .rd_valid_out(rd_valid_out), .rd_ok_out(rd_ok_out), .rd_rec_out(rd_rec_out),
        .fill_out(fill_out), .stamp_out(stamp_out), .blocked_out(blocked_out),
        .internal_fault_report_out(internal_fault_report_out));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [2:0] idx);
        rd_req_in = 1'b1;
        rd_idx_in = idx;
        @(negedge core_clk_in);
        rd_req_in = 1'b0;
        chk(rd_valid_out, 1'b1);
        rec_q = rd_rec_out;
        ok_q = rd_ok_out;
        @(negedge core_clk_in);
    endtask

    task automatic pulse_clr();
        fault_clr_in = 1'b1;
        @(negedge core_clk_in);
        fault_clr_in = 1'b0;
        @(negedge core_clk_in);
    endtask

    task automatic t_reset();
        chk({fill_out, blocked_out, internal_fault_report_out, rd_valid_out}, 7'h00);
        chk(stamp_out, 32'h0);
    endtask

    task automatic t_stamp();
        logic [31:0] s0;
        s0 = stamp_out;
        repeat (10 * TICK) @(negedge core_clk_in);
        chk(stamp_out, s0 + 32'd10);
    endtask

    task automatic t_mask();
        logic [31:0] st;
        fn_mask_in = 16'h0002;
        st = stamp_out;
        src_u.fn_send(4'h1, 8'h11, 1);
        src_u.fn_send(4'h2, 8'h22, 1);
        src_u.fn_send(4'hf, 8'h0f, 1);
        @(negedge core_clk_in);
        chk(fill_out, 4'h2);
        rd(3'h0);
        chk(rec_q, {st, 4'h1, 8'h11});
        rd(3'h1);
        chk(rec_q.evt, {4'hf, 8'h0f});
        rd(3'h5);
        chk(ok_q, 1'b0);
        // Let the rate window roll over before the recorder run
        repeat (210) @(negedge core_clk_in);
    endtask

    task automatic t_rec();
        fn_mask_in = 16'h0000;
        for (int k = 0; k < 11; k++) begin
            src_u.rec_act(k);
            repeat (70) @(negedge core_clk_in);
        end
        chk(fill_out, 4'h8);
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0]);
            chk(rec_q.evt, {elog_pkg::REC_SRC, 8'(i + 3)});
        end
    endtask

    task automatic t_ovl(input int feed);
        int d;
        int w;
        fn_mask_in = 16'h0002;
        d = 0;
        w = 0;
        src_u.fn_send(4'h1, 8'h5a, 10);
        while (blocked_out !== 1'b1 && w < 50) begin
            @(negedge core_clk_in);
            w++;
        end
        chk(blocked_out, 1'b1);
        chk(internal_fault_report_out, 1'b1);
        pulse_clr();
        chk(internal_fault_report_out, 1'b1);
        src_u.fn_send(4'h1, 8'h5b, 1);
        while (d < feed) begin
            src_u.fn_send(4'h1, 8'h5b, 1);
            repeat (18) @(negedge core_clk_in);
            d += 20;
        end
        while (blocked_out === 1'b1 && d < 3000) begin
            @(negedge core_clk_in);
            d++;
        end
        chk(d >= 480 && d >= feed && d < 3000, 1'b1);
        chk(internal_fault_report_out, 1'b1);
        rd(3'h7);
        chk(rec_q.evt.code !== 8'h5b, 1'b1);
        pulse_clr();
        chk(internal_fault_report_out, 1'b0);
        src_u.fn_send(4'h1, 8'h33, 1);
        @(negedge core_clk_in);
        rd(3'h7);
        chk(rec_q.evt.code, 8'h33);
    endtask

    task automatic tally_and_finish();
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Whole run is near 3150 cycles; allow over nine times that
    initial begin
        #300000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        repeat (2) @(negedge core_clk_in);
        nrst_in = 1'b1;
        @(negedge core_clk_in);
        t_reset();
        t_stamp();
        t_mask();
        t_rec();
        t_ovl(0);
        t_ovl(1000);
        tally_and_finish();
    end
endmodule
